// [design/timer_pair_ctrl.sv]
// APB register block for pair mode selection and the pair 01 output flip-flop
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
module timer_pair_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  timer_pair_pkg::taps_type      taps,
    input  wire logic [2:0]               ext_pins,
    input  wire logic [2:0]               even_matches,
    input  wire logic [2:0]               even_overflows,
    input  wire logic                     pair01_mode_dual8,
    input  wire logic                     pair01_even_match,
    input  wire logic                     pair01_odd_match,
    output timer_pair_pkg::pair_ctrl_type pair_ctrl [3],
    output logic                          timer_output_flipflop
);
    import timer_pair_pkg::*;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    mode_reg_type mode_q [3];
    logic         tgl_en_q;
    logic         tgl_src_q;
    logic         ff_q;
    logic         ff_d;
    logic         wr;
    logic         mapped;
    logic         match_sel;
    logic [31:0]  rdata_d;

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == ADDR_FFCR01) || (a == ADDR_MOD67) || (a == ADDR_MOD89) || (a == ADDR_MODAB);
    endfunction

    assign mapped  = is_mapped(paddr);
    assign wr      = psel && penable && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                mode_q[i] <= MOD_RESET;
            end
        end else if (wr) begin
            if (paddr == ADDR_MOD67) mode_q[0] <= pwdata[MODE_HI:EVEN_LO];
            if (paddr == ADDR_MOD89) mode_q[1] <= pwdata[MODE_HI:EVEN_LO];
            if (paddr == ADDR_MODAB) mode_q[2] <= pwdata[MODE_HI:EVEN_LO];
        end
    end

    for (genvar g = 0; g < 3; g++) begin : gen_pair
        pair_clock_select u_sel (
            .mode_reg      (mode_q[g]),
            .taps          (taps),
            .ext_pin       (ext_pins[g]),
            .even_match    (even_matches[g]),
            .even_overflow (even_overflows[g]),
            .ctrl          (pair_ctrl[g])
        );
    end

    // ----------------------------------------------------------------
    // Flip-flop control register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_en_q  <= 1'b0;
            tgl_src_q <= 1'b0;
        end else if (wr && paddr == ADDR_FFCR01) begin
            tgl_en_q  <= pwdata[TGL_EN];
            tgl_src_q <= pwdata[TGL_SRC];
        end
    end

    // Select only counts in dual 8-bit mode
    assign match_sel = (pair01_mode_dual8 && tgl_src_q) ? pair01_odd_match : pair01_even_match;

    always_comb begin
        ff_d = ff_q;
        if (tgl_en_q && match_sel) begin
            ff_d = !ff_q;
        end
        // Toggle, set and clear commands win over a coincident match; the hold code keeps it
        if (wr && paddr == ADDR_FFCR01) begin
            case (pwdata[CMD_HI:CMD_LO])
                CMD_TOGGLE: ff_d = !ff_q;
                CMD_SET:    ff_d = 1'b1;
                CMD_CLEAR:  ff_d = 1'b0;
                default:    ff_d = ff_d;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ff_q <= 1'b0;
        end else begin
            ff_q <= ff_d;
        end
    end

    assign timer_output_flipflop = ff_q;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        case (paddr)
            // Command field is write-only, so it always reads as its reset code
            ADDR_FFCR01: rdata_d[CMD_HI:TGL_SRC] = {CMD_READ, tgl_en_q, tgl_src_q};
            ADDR_MOD67:  rdata_d[MODE_HI:EVEN_LO] = mode_q[0];
            ADDR_MOD89:  rdata_d[MODE_HI:EVEN_LO] = mode_q[1];
            ADDR_MODAB:  rdata_d[MODE_HI:EVEN_LO] = mode_q[2];
            default:     rdata_d      = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

endmodule // timer_pair_ctrl

// [design/timer_pair_pkg.sv]
// Constants, types and register map for the paired timer mode and flip-flop control
// How it works
// - Mode bits 7:6 pick dual 8-bit, cascaded 16-bit, square wave or PWM.
// - PWM period code picks 63, 127 or 255 source clocks; code 00 reserved.
// - Even clock select picks external pin, div1, div4 or div16 prescaler tap.
// - Outside cascade, odd clock select picks even match, div1, div16 or div256.
// - In cascade mode the odd channel counts the even overflow, ignoring its select.
// - Flip-flop command write toggles, sets, clears or holds; reads back as ones.
// - Toggle enable bit 1 lets the selected channel's match toggle the flip-flop.
// - Toggle source select only matters in dual 8-bit mode, else even channel.
// - Flip-flop control bits 7:4 read undefined; here they read zero.
package timer_pair_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_FFCR01  = 12'h000;
    localparam logic [11:0] ADDR_MOD67   = 12'h004;
    localparam logic [11:0] ADDR_MOD89   = 12'h008;
    localparam logic [11:0] ADDR_MODAB   = 12'h00c;
    localparam logic [11:0] ADDR_PWM_SEL = 12'h010;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int MODE_HI   = 7;
    localparam int MODE_LO   = 6;
    localparam int PERIOD_HI = 5;
    localparam int PERIOD_LO = 4;
    localparam int ODD_HI    = 3;
    localparam int ODD_LO    = 2;
    localparam int EVEN_HI   = 1;
    localparam int EVEN_LO   = 0;
    localparam int CMD_HI    = 3;
    localparam int CMD_LO    = 2;
    localparam int TGL_EN    = 1;
    localparam int TGL_SRC   = 0;

    localparam logic [7:0] MOD_RESET  = 8'h00;
    localparam logic [1:0] CMD_RESET  = 2'h3;
    localparam logic [1:0] CMD_READ   = 2'h3;

    localparam logic [1:0] CMD_TOGGLE = 2'h0;
    localparam logic [1:0] CMD_SET    = 2'h1;
    localparam logic [1:0] CMD_CLEAR  = 2'h2;

    localparam logic [7:0] PERIOD_63  = 8'h3f;
    localparam logic [7:0] PERIOD_127 = 8'h7f;
    localparam logic [7:0] PERIOD_255 = 8'hff;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DUAL8   = 2'b00,
        MODE_CASCADE = 2'b01,
        MODE_SQUARE  = 2'b10,
        MODE_PWM     = 2'b11
    } mode_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] period;
        logic [1:0] odd_sel;
        logic [1:0] even_sel;
    } mode_reg_type;

    typedef struct packed {
        logic tap_div1;
        logic tap_div4;
        logic tap_div16;
        logic tap_div256;
    } taps_type;

    typedef struct packed {
        logic       even_clk;
        logic       odd_clk;
        logic       cascade;
        logic       pwm;
        logic       square;
        logic [7:0] pwm_period;
    } pair_ctrl_type;

endpackage

// [design/pair_clock_select.sv]
// Clock source and mode decode for one even/odd timer pair
`timescale 1ns/10ps
module pair_clock_select (
    input  timer_pair_pkg::mode_reg_type  mode_reg,
    input  timer_pair_pkg::taps_type      taps,
    input  wire logic                     ext_pin,
    input  wire logic                     even_match,
    input  wire logic                     even_overflow,
    output timer_pair_pkg::pair_ctrl_type ctrl
);
    import timer_pair_pkg::*;

    always_comb begin
        ctrl = '0;
        case (mode_reg.even_sel)
            2'b00:   ctrl.even_clk = ext_pin;
            2'b01:   ctrl.even_clk = taps.tap_div1;
            2'b10:   ctrl.even_clk = taps.tap_div4;
            2'b11:   ctrl.even_clk = taps.tap_div16;
            default: ctrl.even_clk = 1'b0;
        endcase
        if (mode_type'(mode_reg.mode) == MODE_CASCADE) begin
            ctrl.odd_clk = even_overflow;
        end else begin
            case (mode_reg.odd_sel)
                2'b00:   ctrl.odd_clk = even_match;
                2'b01:   ctrl.odd_clk = taps.tap_div1;
                2'b10:   ctrl.odd_clk = taps.tap_div16;
                2'b11:   ctrl.odd_clk = taps.tap_div256;
                default: ctrl.odd_clk = 1'b0;
            endcase
        end
        ctrl.cascade = (mode_type'(mode_reg.mode) == MODE_CASCADE);
        ctrl.square  = (mode_type'(mode_reg.mode) == MODE_SQUARE);
        ctrl.pwm     = (mode_type'(mode_reg.mode) == MODE_PWM);
        case (mode_reg.period)
            2'b01:   ctrl.pwm_period = PERIOD_63;
            2'b10:   ctrl.pwm_period = PERIOD_127;
            2'b11:   ctrl.pwm_period = PERIOD_255;
            default: ctrl.pwm_period = '0;
        endcase
    end

endmodule // pair_clock_select

// [testbench/timer_pair_props.sv]
// Port assertions for the pair mode and flip-flop control block
`timescale 1ns/10ps
module timer_pair_props (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input timer_pair_pkg::pair_ctrl_type pair_ctrl [3],
    input wire logic                     timer_output_flipflop
);
    import timer_pair_pkg::*;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_ff;
    logic wr_m0;
    assign wr_ff = psel && penable && pwrite && paddr == ADDR_FFCR01;
    assign wr_m0 = psel && penable && pwrite && paddr == ADDR_MOD67;
    property p_ready; psel && penable |-> pready; endproperty
    property p_err; psel && penable && paddr == ADDR_PWM_SEL |-> pslverr; endproperty
    property p_set; wr_ff && pwdata[3:2] == CMD_SET |=> timer_output_flipflop; endproperty
    property p_clear; wr_ff && pwdata[3:2] == CMD_CLEAR |=> !timer_output_flipflop; endproperty
    property p_toggle;
        wr_ff && pwdata[3:2] == CMD_TOGGLE |=> timer_output_flipflop != $past(timer_output_flipflop);
    endproperty
    property p_cmd_read;
        psel && !penable && !pwrite && paddr == ADDR_FFCR01 |=> prdata[3:2] == CMD_READ;
    endproperty
    property p_cascade; wr_m0 |=> pair_ctrl[0].cascade == ($past(pwdata[7:6]) == MODE_CASCADE); endproperty
    property p_pwm; wr_m0 |=> pair_ctrl[0].pwm == ($past(pwdata[7:6]) == MODE_PWM); endproperty
    property p_period;
        wr_m0 && pwdata[7:6] == MODE_PWM && pwdata[5:4] == 2'h1 |=> pair_ctrl[0].pwm_period == PERIOD_63;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_err: assert property (p_err) else $error("no pslverr on unmapped");
    a_set: assert property (p_set) else $error("flip-flop not set");
    a_clear: assert property (p_clear) else $error("flip-flop not cleared");
    a_toggle: assert property (p_toggle) else $error("flip-flop not toggled");
    a_cmd_read: assert property (p_cmd_read) else $error("command field not ones");
    a_cascade: assert property (p_cascade) else $error("cascade decode wrong");
    a_pwm: assert property (p_pwm) else $error("pwm decode wrong");
    a_period: assert property (p_period) else $error("pwm period wrong");
    c_err: cover property (psel && penable && paddr == ADDR_PWM_SEL && pslverr);
    c_toggle: cover property (wr_ff && pwdata[3:2] == CMD_TOGGLE);
    c_cascade: cover property (wr_m0 && pwdata[7:6] == MODE_CASCADE);
endmodule // timer_pair_props

// [testbench/timer_pair_ctrl_tb.sv]
// Register-level testbench for the pair mode and flip-flop control block
`timescale 1ns/10ps
module timer_pair_ctrl_tb;
    import timer_pair_pkg::*;
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    logic          clk, rst, psel, penable, pwrite, pready, pslverr, err, f;
    logic          pair01_mode_dual8, pair01_even_match, pair01_odd_match, timer_output_flipflop;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [2:0]    ext_pins, even_matches, even_overflows;
    taps_type      taps;
    pair_ctrl_type pair_ctrl [3];
    int            mismatches, tests_run, oi;
    logic [1:0]    cmd [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h3};
    logic          fx [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    // Enable, select, dual mode, odd pulse, toggles
    logic [4:0]    tt [7] = '{5'h15, 5'h16, 5'h1f, 5'h1c, 5'h19, 5'h1a, 5'h04};
    timer_pair_ctrl DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .taps, .ext_pins, .even_matches, .even_overflows, .pair01_mode_dual8, .pair01_even_match,
        .pair01_odd_match, .pair_ctrl, .timer_output_flipflop);
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task test_done;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin mismatches++; test_done; end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    function logic bitof(int i, int k);
        return i[k];
    endfunction
    initial begin
        rst <= 1'b1;
        pair01_mode_dual8 <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {pair01_even_match, pair01_odd_match, ext_pins, even_matches, even_overflows, taps} <= '0;
        repeat (3) @(posedge clk);
        rst <= 0;
        apb(0, ADDR_FFCR01, 0); chk("ffcr", 32'hc, 32'(rd[3:0]));
        chk("err", 0, 32'(err));
        chk("ff", 0, 32'(timer_output_flipflop));
        for (int q = 0; q < 3; q++) begin apb(0, ADDR_MOD67 + 12'(4 * q), 0); chk("mod", 0, rd); end
        apb(1, ADDR_PWM_SEL, 32'hff); chk("err", 1, 32'(err));
        apb(0, ADDR_PWM_SEL, 0); chk("err", 1, 32'(err)); chk("rd", 0, rd);
        apb(1, ADDR_MOD89, 32'hffffffa5); apb(0, ADDR_MOD89, 0); chk("mod89", 32'ha5, rd);
        for (int q = 0; q < 3; q++) for (int m = 0; m < 4; m++) for (int e = 0; e < 4; e++) begin
            apb(1, ADDR_MOD67 + 12'(4 * q), 32'({2'(m), 2'(e), 2'(e), 2'(e)}));
            oi = m == 1 ? 3 : e == 0 ? 2 : e == 1 ? 4 : e == 2 ? 6 : 7;
            chk("mode", 32'({m == 1, m == 3, m == 2}), 32'({pair_ctrl[q].cascade, pair_ctrl[q].pwm,
                pair_ctrl[q].square}));
            if (m == 3 && e != 0) chk("period", 32'(8'hff >> (3 - e)), 32'(pair_ctrl[q].pwm_period));
            for (int k = 0; k < 3; k++) begin
                ext_pins <= {3{bitof(1, k)}}; even_matches <= {3{bitof(2, k)}};
                even_overflows <= {3{bitof(3, k)}}; taps <= {bitof(4, k), bitof(5, k), bitof(6, k), bitof(7, k)};
                @(posedge clk);
                chk("even", 32'(bitof(e == 0 ? 1 : e + 3, k)), 32'(pair_ctrl[q].even_clk));
                chk("odd", 32'(bitof(oi, k)), 32'(pair_ctrl[q].odd_clk));
            end
        end
        for (int i = 0; i < 5; i++) begin
            apb(1, ADDR_FFCR01, 32'({cmd[i], 2'b00})); chk("ff", 32'(fx[i]), 32'(timer_output_flipflop));
            apb(0, ADDR_FFCR01, 0); chk("cmd", 32'h3, 32'(rd[3:2]));
        end
        for (int i = 0; i < 7; i++) begin
            pair01_mode_dual8 <= tt[i][2];
            apb(1, ADDR_FFCR01, 32'({2'b11, tt[i][4:3]}));
            f = timer_output_flipflop;
            pair01_even_match <= !tt[i][1]; pair01_odd_match <= tt[i][1];
            @(posedge clk);
            pair01_even_match <= 0; pair01_odd_match <= 0;
            repeat (2) @(posedge clk);
            chk("tgl", 32'(f ^ tt[i][0]), 32'(timer_output_flipflop));
        end
        test_done;
    end
endmodule // timer_pair_ctrl_tb
bind timer_pair_ctrl timer_pair_props u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pair_ctrl, .timer_output_flipflop);
